// ==== include/mrs_pkg.sv ====
`default_nettype none
package mrs_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int PWM_BASE_NS = 30500;
  localparam int PWM_STEP_NS = 400;
  localparam int PWM_BASE_CYC = PWM_BASE_NS / CLK_PERIOD_NS;
  localparam int PWM_STEP_CYC = PWM_STEP_NS / CLK_PERIOD_NS;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYC = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LP_ENTRY_TIME_US = 1000;
  localparam int LP_ENTRY_CYC = (LP_ENTRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Widths and fixed levels
  // ----------------------------------------------------------------------
  localparam int VW = 10;
  localparam int REFW = 14;
  localparam int PWMW = 15;
  localparam int INITW = 8;
  localparam int LPW = 17;
  localparam int FGW = 24;
  localparam logic [VW-1:0] RELEASE_LEVEL = 10'h040;
  localparam logic [VW-1:0] VOLT_ZERO = 10'h000;
  localparam logic [2:0] ALL_OFF = 3'h0;
  localparam logic [2:0] ALL_ON = 3'h7;

  // ----------------------------------------------------------------------
  // Run states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_COAST = 5'h01,
    ST_LOWPWR = 5'h02,
    ST_INIT = 5'h04,
    ST_UBRAKE = 5'h08,
    ST_RUN = 5'h10
  } mrs_state_t;

endpackage

`default_nettype wire

// ==== tb/mrs_motor_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mrs_motor_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] high_on,
  input wire logic [2:0] low_on,
  input wire logic slip,
  output logic [13:0] estimated_speed,
  output logic desync_detect
);
  // --------------------------------------------------------------------
  // Rotor
  // --------------------------------------------------------------------
  // Inertia is not modelled: the rotor is at full speed once driven and
  // stops when every switch opens, so feedback rates are easy to predict.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      estimated_speed <= 14'h0000;
    else if (high_on != mrs_pkg::ALL_OFF)
      estimated_speed <= 14'h3FFF;
    else if (low_on == mrs_pkg::ALL_OFF)
      estimated_speed <= 14'h0000;
  end
  assign desync_detect = slip;
endmodule // mrs_motor_model
`default_nettype wire

// ==== tb/mrs_run_ctrl_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module mrs_run_ctrl_checker #(
  parameter int LP_ENTRY_CYCLES = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic motor_enable,
  input wire logic brake_request,
  input wire logic direction_bit,
  input wire logic direction_pin,
  input wire logic [2:0] high_on,
  input wire logic [2:0] low_on,
  input wire logic regulation_suspend,
  input wire logic rotation_reverse,
  input wire logic running,
  input wire logic low_power_mode,
  input wire logic clear_faults,
  input wire logic startup_request,
  input wire logic desync_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  enable_off_a: assert property (
    !motor_enable |=> high_on == 3'h0 && low_on == 3'h0 && !running)
    else $error("gates driven while disabled");
  brake_coast_a: assert property (
    !motor_enable |=> !regulation_suspend)
    else $error("brake acted while disabled");
  brake_short_a: assert property (
    regulation_suspend |-> low_on == 3'h7 && high_on == 3'h0)
    else $error("braking without all low sides on");
  dir_xor_a: assert property (
    1'b1 |=> rotation_reverse == $past(direction_bit ^ direction_pin))
    else $error("direction not the xor of bit and pin");
  brake_run_a: assert property (
    (motor_enable && brake_request) [*2] |=> !running)
    else $error("running while brake requested");
  desync_idle_a: assert property (
    !running [*2] |-> !desync_flag)
    else $error("desync flag set while not running");
  startup_run_a: assert property (
    startup_request |=> running && !startup_request)
    else $error("startup pulse wrong");
  lp_clear_a: assert property (
    clear_faults |=> !clear_faults && low_power_mode)
    else $error("fault clear pulse wrong");
  lp_off_a: assert property (
    low_power_mode |-> high_on == 3'h0 && low_on == 3'h0)
    else $error("gates on in low power");
endmodule // mrs_run_ctrl_checker
bind mrs_run_ctrl mrs_run_ctrl_checker #(.LP_ENTRY_CYCLES(LP_ENTRY_CYCLES)) chk_u (
  .clk, .resetn, .motor_enable, .brake_request, .direction_bit, .direction_pin,
  .high_on, .low_on, .regulation_suspend, .rotation_reverse, .running,
  .low_power_mode, .clear_faults, .startup_request, .desync_flag);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // --------------------------------------------------------------------
  // Stimulus and design
  // --------------------------------------------------------------------
  typedef struct packed {
    logic db;
    logic dp;
    logic [9:0] val;
    logic [3:0] mul;
    logic [9:0] pin;
    logic rev;
    logic [13:0] ref_v;
  } mrs_row_t;
  logic clk = 1'b0, resetn = 1'b0, motor_enable = 1'b0, brake_request = 1'b0;
  logic direction_bit = 1'b0, direction_pin = 1'b0, speed_source_select = 1'b1;
  logic slip = 1'b0, fp;
  logic [9:0] register_speed_value = 10'h000, speed_control_pin = 10'h000;
  logic [9:0] max_speed_voltage = 10'h300, min_speed_voltage = 10'h100;
  logic [9:0] excitation_start_voltage = 10'h180, low_power_entry_voltage = 10'h050;
  logic [9:0] max_reference_speed = 10'h3E8, min_reference_speed = 10'h064;
  logic [3:0] speed_range_multiplier = 4'h1;
  logic [7:0] pwm_period_field = 8'h00;
  logic [2:0] high_on, low_on;
  logic [13:0] estimated_speed, speed_reference;
  logic desync_detect, regulation_suspend, rotation_reverse, running, low_power_mode;
  logic clear_faults, startup_request, speed_feedback_pin, desync_flag, pwm_period_tick;
  int fail_count = 0, checked = 0, clr_seen = 0, g, tog;
  mrs_row_t rows [4] = '{'{1'b0, 1'b0, 10'h3FF, 4'hF, 10'h000, 1'b0, 14'h3BF1},
    '{1'b0, 1'b1, 10'h001, 4'h1, 10'h3FF, 1'b1, 14'h0001},
    '{1'b1, 1'b0, 10'h064, 4'hA, 10'h200, 1'b1, 14'h03E8},
    '{1'b1, 1'b1, 10'h000, 4'h7, 10'h041, 1'b0, 14'h0000}};
  always #4 clk = ~clk;
  always @(posedge clk) if (clear_faults === 1'b1) clr_seen++;
  mrs_run_ctrl #(.LP_ENTRY_CYCLES(20)) dut_u (
    .clk, .resetn, .motor_enable, .brake_request, .direction_bit, .direction_pin,
    .speed_source_select, .register_speed_value, .speed_control_pin,
    .max_speed_voltage, .min_speed_voltage, .excitation_start_voltage,
    .low_power_entry_voltage, .max_reference_speed, .min_reference_speed,
    .speed_range_multiplier, .pwm_period_field, .duty_u(15'h0800), .duty_v(15'h0400),
    .duty_w(15'h0200), .estimated_speed, .desync_detect, .high_on, .low_on,
    .regulation_suspend, .rotation_reverse, .running, .low_power_mode, .clear_faults,
    .startup_request, .speed_reference, .speed_feedback_pin, .desync_flag,
    .pwm_period_tick);
  mrs_motor_model motor_u (.clk, .resetn, .high_on, .low_on, .slip, .estimated_speed,
    .desync_detect);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Counts cycles up to the next period tick; capped so a dead tick cannot hang.
  task automatic gap;
    g = 0;
    do
    begin
      @(negedge clk);
      g++;
    end
    while (pwm_period_tick !== 1'b1 && g < 9000);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #480000;
    fail_count++;
    complete_run;
  end
  initial
  begin
    cyc(3);
    resetn = 1'b1;
    cyc(2);
    chk("idle", {6'h00, high_on, low_on, running, low_power_mode}, 14'h0000);
    motor_enable = 1'b1;
    foreach (rows[i])
    begin
      direction_bit = rows[i].db;
      direction_pin = rows[i].dp;
      register_speed_value = rows[i].val;
      speed_range_multiplier = rows[i].mul;
      speed_control_pin = rows[i].pin;
      cyc(4);
      chk("reverse", {13'h0000, rotation_reverse}, {13'h0000, rows[i].rev});
      chk("reference", speed_reference, rows[i].ref_v);
      chk("running", {13'h0000, running}, 14'h0001);
    end
    for (int n = 0; n < 72; n += 71)
    begin
      pwm_period_field = n[7:0];
      gap();
      gap();
      gap();
      chk("period", g[13:0], 14'(mrs_pkg::PWM_BASE_CYC + n * mrs_pkg::PWM_STEP_CYC));
    end
    tog = 0;
    repeat (2048)
    begin
      fp = speed_feedback_pin;
      @(negedge clk);
      tog += int'(speed_feedback_pin !== fp);
    end
    chk("feedback", 14'(tog >= 3 && tog <= 5), 14'h0001);
    slip = 1'b1;
    cyc(3);
    chk("desync", {13'h0000, desync_flag}, 14'h0001);
    slip = 1'b0;
    brake_request = 1'b1;
    cyc(3);
    chk("brake", {8'h00, high_on, low_on}, 14'h0007);
    chk("brake run", {11'h000, regulation_suspend, running, desync_flag}, 14'h0004);
    motor_enable = 1'b0;
    cyc(2);
    chk("coast", {10'h000, low_on, regulation_suspend}, 14'h0000);
    speed_source_select = 1'b0;
    brake_request = 1'b0;
    speed_control_pin = 10'h000;
    speed_range_multiplier = 4'h1;
    cyc(2);
    motor_enable = 1'b1;
    cyc(200);
    chk("zero pin", {13'h0000, low_power_mode}, 14'h0001);
    speed_control_pin = 10'h041;
    cyc(60);
    chk("init", {7'h00, high_on, low_on, low_power_mode}, 14'h0000);
    cyc(90);
    chk("user brake", {7'h00, high_on, low_on, low_power_mode}, 14'h000E);
    speed_control_pin = 10'h200;
    cyc(6);
    chk("run", {13'h0000, running}, 14'h0001);
    chk("ref mid", speed_reference, 14'h0226);
    speed_control_pin = 10'h3FF;
    cyc(4);
    chk("ref clamp", speed_reference, 14'h03E8);
    speed_control_pin = 10'h120;
    cyc(4);
    chk("hold run", {13'h0000, running}, 14'h0001);
    speed_control_pin = 10'h0FF;
    cyc(4);
    chk("below min", {10'h000, running, low_on}, 14'h0007);
    clr_seen = 0;
    speed_control_pin = 10'h040;
    cyc(40);
    chk("entry", {13'h0000, low_power_mode}, 14'h0001);
    chk("fault clear", clr_seen[13:0], 14'h0001);
    // A reset while in low power must restart the pin sequence with the gates off.
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    cyc(2);
    chk("reset again", {6'h00, high_on, low_on, running, low_power_mode}, 14'h0000);
    complete_run;
  end
endmodule // testbench
`default_nettype wire

// ==== verilog/mrs_run_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

module mrs_run_ctrl #(
  parameter int LP_ENTRY_CYCLES = mrs_pkg::LP_ENTRY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic motor_enable,
  input wire logic brake_request,
  input wire logic direction_bit,
  input wire logic direction_pin,
  input wire logic speed_source_select,
  input wire logic [9:0] register_speed_value,
  input wire logic [9:0] speed_control_pin,
  input wire logic [9:0] max_speed_voltage,
  input wire logic [9:0] min_speed_voltage,
  input wire logic [9:0] excitation_start_voltage,
  input wire logic [9:0] low_power_entry_voltage,
  input wire logic [9:0] max_reference_speed,
  input wire logic [9:0] min_reference_speed,
  input wire logic [3:0] speed_range_multiplier,
  input wire logic [7:0] pwm_period_field,
  input wire logic [14:0] duty_u,
  input wire logic [14:0] duty_v,
  input wire logic [14:0] duty_w,
  input wire logic [13:0] estimated_speed,
  input wire logic desync_detect,
  output logic [2:0] high_on,
  output logic [2:0] low_on,
  output logic regulation_suspend,
  output logic rotation_reverse,
  output logic running,
  output logic low_power_mode,
  output logic clear_faults,
  output logic startup_request,
  output logic [13:0] speed_reference,
  output logic speed_feedback_pin,
  output logic desync_flag,
  output logic pwm_period_tick
);

  // ----------------------------------------------------------------------
  // Pin comparisons and speed law
  // ----------------------------------------------------------------------
  mrs_pkg::mrs_state_t st_q, st_d;
  logic [mrs_pkg::VW-1:0] entry_level;
  logic [mrs_pkg::VW-1:0] span_v, off_v, span_s;
  logic [19:0] prod;
  logic [9:0] interp;
  logic [9:0] setting;
  logic lp_cond, lp_timeout, braking, run_now;
  logic [mrs_pkg::LPW-1:0] lp_cnt_q;
  logic [mrs_pkg::INITW-1:0] init_cnt_q;
  logic init_done;

  // A programmed entry level above release would never be reached first.
  assign entry_level = (low_power_entry_voltage > mrs_pkg::RELEASE_LEVEL) ?
                       mrs_pkg::RELEASE_LEVEL : low_power_entry_voltage;
  assign lp_cond = speed_control_pin <= entry_level;
  assign lp_timeout = lp_cnt_q >= mrs_pkg::LPW'(LP_ENTRY_CYCLES - 1);
  assign init_done = init_cnt_q >= mrs_pkg::INITW'(mrs_pkg::INIT_CYC - 1);

  assign span_v = max_speed_voltage - min_speed_voltage;
  assign off_v = speed_control_pin - min_speed_voltage;
  assign span_s = max_reference_speed - min_reference_speed;
  assign prod = off_v * span_s;

  // The divider is combinational; the result is registered, so the law only
  // needs to settle within one clock. Settings with max below min clamp high.
  always_comb
  begin
    interp = max_reference_speed;
    if (max_speed_voltage > min_speed_voltage)
    begin
      if (speed_control_pin <= min_speed_voltage)
        interp = min_reference_speed;
      else if (speed_control_pin < max_speed_voltage)
        interp = min_reference_speed + 10'(prod / {10'h000, span_v});
    end
  end

  assign setting = speed_source_select ? register_speed_value : interp;

  // ----------------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (!motor_enable)
      st_d = mrs_pkg::ST_COAST;
    else if (speed_source_select)
      st_d = mrs_pkg::ST_RUN;
    else
    begin
      case (st_q)
        mrs_pkg::ST_COAST: st_d = mrs_pkg::ST_INIT;
        mrs_pkg::ST_LOWPWR:
          if (speed_control_pin > mrs_pkg::RELEASE_LEVEL)
            st_d = mrs_pkg::ST_INIT;
        mrs_pkg::ST_INIT:
          if (init_done)
            st_d = mrs_pkg::ST_UBRAKE;
        mrs_pkg::ST_UBRAKE:
          if (speed_control_pin > excitation_start_voltage)
            st_d = mrs_pkg::ST_RUN;
        mrs_pkg::ST_RUN:
          if (speed_control_pin < min_speed_voltage)
            st_d = mrs_pkg::ST_UBRAKE;
        default: st_d = mrs_pkg::ST_COAST;
      endcase
      if ((st_q == mrs_pkg::ST_UBRAKE || st_q == mrs_pkg::ST_RUN ||
           st_q == mrs_pkg::ST_INIT) &&
          (speed_control_pin == mrs_pkg::VOLT_ZERO || lp_timeout))
        st_d = mrs_pkg::ST_LOWPWR;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      st_q <= mrs_pkg::ST_COAST;
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------------
  // Low power entry timer and initialisation timer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
      lp_cnt_q <= '0;
    else if (speed_source_select || !lp_cond ||
             !(st_q == mrs_pkg::ST_UBRAKE || st_q == mrs_pkg::ST_RUN))
      lp_cnt_q <= '0;
    else if (!lp_timeout)
      lp_cnt_q <= lp_cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      init_cnt_q <= '0;
    else if (st_q != mrs_pkg::ST_INIT)
      init_cnt_q <= '0;
    else if (!init_done)
      init_cnt_q <= init_cnt_q + 1'b1;
  end

  // ----------------------------------------------------------------------
  // Drive decisions
  // ----------------------------------------------------------------------
  assign braking = motor_enable &&
                   (st_q == mrs_pkg::ST_UBRAKE ||
                    (st_q == mrs_pkg::ST_RUN && brake_request));
  assign run_now = motor_enable && !brake_request && st_q == mrs_pkg::ST_RUN;

  // ----------------------------------------------------------------------
  // PWM period generator
  // ----------------------------------------------------------------------
  logic [mrs_pkg::PWMW-1:0] pwm_cnt_q, period;
  logic [2:0] pwm_q;
  logic [mrs_pkg::PWMW-1:0] duty_v_eff, duty_w_eff;

  assign period = mrs_pkg::PWMW'(mrs_pkg::PWM_BASE_CYC) +
                  mrs_pkg::PWMW'(pwm_period_field * mrs_pkg::PWM_STEP_CYC);
  // Reverse swaps the V and W drive so each phase lags instead of leading.
  assign duty_v_eff = rotation_reverse ? duty_w : duty_v;
  assign duty_w_eff = rotation_reverse ? duty_v : duty_w;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pwm_cnt_q <= '0;
      pwm_period_tick <= 1'b0;
    end
    else
    begin
      pwm_period_tick <= pwm_cnt_q >= period - 1'b1;
      if (pwm_cnt_q >= period - 1'b1)
        pwm_cnt_q <= '0;
      else
        pwm_cnt_q <= pwm_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      pwm_q <= mrs_pkg::ALL_OFF;
    else
      pwm_q <= {pwm_cnt_q < duty_w_eff, pwm_cnt_q < duty_v_eff, pwm_cnt_q < duty_u};
  end

  // ----------------------------------------------------------------------
  // Gate outputs
  // ----------------------------------------------------------------------
  // No dead time is inserted here; the gate stage downstream owns that.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      high_on <= mrs_pkg::ALL_OFF;
      low_on <= mrs_pkg::ALL_OFF;
      regulation_suspend <= 1'b0;
    end
    else if (!motor_enable || !(st_q == mrs_pkg::ST_UBRAKE || st_q == mrs_pkg::ST_RUN))
    begin
      high_on <= mrs_pkg::ALL_OFF;
      low_on <= mrs_pkg::ALL_OFF;
      regulation_suspend <= 1'b0;
    end
    else if (braking)
    begin
      high_on <= mrs_pkg::ALL_OFF;
      low_on <= mrs_pkg::ALL_ON;
      regulation_suspend <= 1'b1;
    end
    else
    begin
      high_on <= pwm_q;
      low_on <= ~pwm_q;
      regulation_suspend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status and reference outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rotation_reverse <= 1'b0;
      running <= 1'b0;
      low_power_mode <= 1'b0;
      clear_faults <= 1'b0;
      startup_request <= 1'b0;
      speed_reference <= '0;
    end
    else
    begin
      rotation_reverse <= direction_bit ^ direction_pin;
      running <= run_now;
      low_power_mode <= st_q == mrs_pkg::ST_LOWPWR;
      clear_faults <= st_d == mrs_pkg::ST_LOWPWR && st_q != mrs_pkg::ST_LOWPWR;
      startup_request <= st_d == mrs_pkg::ST_RUN && st_q != mrs_pkg::ST_RUN &&
                         !brake_request;
      speed_reference <= setting * speed_range_multiplier;
    end
  end

  // Desync: the clear conditions take priority over the set condition.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      desync_flag <= 1'b0;
    else if (!run_now || st_q == mrs_pkg::ST_LOWPWR)
      desync_flag <= 1'b0;
    else if (desync_detect)
      desync_flag <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Speed feedback pulse train
  // ----------------------------------------------------------------------
  // Phase accumulator: output frequency is estimated_speed * fclk / 2^24.
  logic [mrs_pkg::FGW-1:0] fg_acc_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fg_acc_q <= '0;
      speed_feedback_pin <= 1'b0;
    end
    else if (!run_now)
    begin
      fg_acc_q <= '0;
      speed_feedback_pin <= 1'b0;
    end
    else
    begin
      fg_acc_q <= fg_acc_q + mrs_pkg::FGW'(estimated_speed);
      speed_feedback_pin <= fg_acc_q[mrs_pkg::FGW-1];
    end
  end

endmodule // mrs_run_ctrl

`default_nettype wire
